// ==== uvs_cfg.svh ====
// constants for the isochronous video stream link
// assumes inclusion by the package and both ends
`ifndef UVS_CFG_SVH
`define UVS_CFG_SVH
`define UVS_EP_ADDR 8'h81
`define UVS_EP_ATTR 8'h01
`define UVS_EP_INTERVAL 8'h01
`define UVS_IFACE_NUM 8'h01
`define UVS_EOF_BYTE 8'hFF
`define UVS_EOF_LEN 3'h4
`define UVS_MPS_HI_1 11'h1C0
`define UVS_MPS_HI_2 11'h2C0
`define UVS_MPS_HI_3 11'h3C0
`define UVS_MPS_LO_1 11'h140
`define UVS_MPS_LO_2 11'h268
`define UVS_MPS_LO_3 11'h380
`define UVS_FRAME_NS 1000000
`define UVS_CLK_NS 5
`define UVS_FRAME_CYC (`UVS_FRAME_NS / `UVS_CLK_NS)
`endif

// ==== uvs_pkg.sv ====
// types shared by both ends of the video stream link
// assumes uvs_cfg.svh is on the include path
`include "uvs_cfg.svh"
package uvs_pkg;
	typedef logic [10:0] uvs_len_t;
	typedef logic [1:0] uvs_alt_t;
	typedef enum logic [2:0] {
		UVS_IDLE = 3'h1,
		UVS_SEND = 3'h2,
		UVS_MARK = 3'h4
	} uvs_tx_e;
	function automatic uvs_len_t uvs_mps(input uvs_alt_t alt,
		input logic bw_hi);
		uvs_len_t r;
		r = 11'h000;
		case (alt)
			2'h1: r = bw_hi ? `UVS_MPS_HI_1 : `UVS_MPS_LO_1;
			2'h2: r = bw_hi ? `UVS_MPS_HI_2 : `UVS_MPS_LO_2;
			2'h3: r = bw_hi ? `UVS_MPS_HI_3 : `UVS_MPS_LO_3;
			default: r = 11'h000;
		endcase
		return r;
	endfunction
endpackage

// ==== uvs_link_if.sv ====
// link between the camera end and the host end of the video stream
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface uvs_link_if;
	logic [1:0] alt_set;
	logic alt_set_stb;
	logic in_token;
	logic [7:0] ep_addr;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_last;
	logic [10:0] mps;
	modport dev (input alt_set, input alt_set_stb, input in_token,
		input ep_addr, output rx_data, output rx_valid, output rx_last,
		output mps);
	modport host (output alt_set, output alt_set_stb, output in_token,
		output ep_addr, input rx_data, input rx_valid, input rx_last,
		input mps);
endinterface

// ==== uvs_fifo.sv ====
// flop-based fifo with valid/ready on both sides
// assumes one synchronous clock and reset
`timescale 1ns/1ps
module uvs_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("uvs_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
	logic wr, rd;
	always_comb
	begin
		in_ready = (wp_reg - rp_reg) != DEPTH[AW:0];
		out_valid = wp_reg != rp_reg;
		out_data = mem_reg[rp_reg[AW-1:0]];
		wr = in_valid && in_ready;
		rd = out_valid && out_ready;
		wp_next = wp_reg + {{AW{1'b0}}, wr};
		rp_next = rp_reg + {{AW{1'b0}}, rd};
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
		end
		else
		begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
		end
		if (wr)
			mem_reg[wp_reg[AW-1:0]] <= in_data;
	end
endmodule // uvs_fifo

// ==== uvs_dev.sv ====
// camera end: buffers video, answers in tokens on the iso endpoint
// assumes the host end drives tokens and alternate setting selects
// Notes on behaviour
// - video leaves only through iso endpoint 1
// - four alternate settings on interface 1
// - bandwidth strap pulled up; low picks lower table
// - strap high: 0, 448, 704, 960 bytes
// - strap low: 0, 320, 616, 896 bytes
// - setting 0 always reserves zero bytes
// - bandwidth counted in bytes per 1 ms frame
// - each token sends held bytes, capped at size
// - uncompressed: same as compressed, short packets when buffer runs dry
// - compressed: packets may be short, frames vary
// - four 0xFF bytes follow each image frame whose end byte enters the buffer
// - image data never holds four 0xFF run
// - host picks setting 0 on driver load
// - host asks once for bus_max_alt, or setting 1 if that is 0
// - host issues one token per 1 ms frame
// - host finds frame end at four 0xFF, drops 0xFF bytes, checks nothing else
// - descriptor: address 0x81, iso, interval one
// - reported packet size follows bandwidth strap
`timescale 1ns/1ps
module uvs_dev
	import uvs_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// strap, high when left open
	input wire logic bw_hi,
	// video source
	input wire logic [7:0] vid_data,
	input wire logic vid_valid,
	input wire logic vid_eof,
	input wire logic compress_en,
	output logic vid_ready,
	// link to host
	uvs_link_if.dev lnk,
	// descriptor view
	output logic [7:0] desc_ep_addr,
	output logic [7:0] desc_ep_attr,
	output logic [7:0] desc_interval,
	output logic [10:0] desc_mps
);
	initial
	begin
		if (DEPTH < 4)
			$error("uvs_dev depth too small");
	end
	uvs_alt_t alt_reg, alt_next;
	uvs_tx_e st_reg, st_next;
	uvs_len_t cnt_reg, cnt_next, mps_reg, mps_next;
	logic [1:0] ffrun_reg, ffrun_next;
	logic [2:0] mk_reg, mk_next;
	logic bw_reg, bw_next;
	logic [7:0] dat_reg, dat_next;
	logic val_reg, val_next, last_reg, last_next;
	logic [8:0] f_in, f_out;
	logic f_iv, f_ir, f_ov, f_or;
	logic [7:0] src_byte;
	logic is_ff, tok;
	// the 4th 0xFF of a run is dropped so data can never mimic the marker
	always_comb
	begin
		is_ff = vid_data == `UVS_EOF_BYTE;
		src_byte = vid_data;
		f_in = {vid_eof, src_byte};
		f_iv = vid_valid && alt_reg != 2'h0 &&
			!(is_ff && ffrun_reg == 2'h3);
		// setting 0 swallows the video instead of stalling the source
		vid_ready = (alt_reg == 2'h0) ? 1'b1 : f_ir;
		ffrun_next = ffrun_reg;
		if (vid_valid && vid_ready)
			ffrun_next = (is_ff && !vid_eof && ffrun_reg != 2'h3) ?
				ffrun_reg + 2'h1 : (is_ff ? ffrun_reg : 2'h0);
	end
	uvs_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data(f_in),
		.in_valid(f_iv),
		.in_ready(f_ir),
		.out_data(f_out),
		.out_valid(f_ov),
		.out_ready(f_or)
	);
	always_comb
	begin
		tok = lnk.in_token && lnk.ep_addr == `UVS_EP_ADDR;
		alt_next = lnk.alt_set_stb ? lnk.alt_set : alt_reg;
		bw_next = bw_hi;
		mps_next = uvs_mps(alt_reg, bw_reg);
		st_next = st_reg;
		cnt_next = cnt_reg;
		mk_next = mk_reg;
		dat_next = 8'h00;
		val_next = 1'b0;
		last_next = 1'b0;
		f_or = 1'b0;
		case (st_reg)
			UVS_IDLE:
			begin
				// one packet per token, token once per 1 ms frame
				if (tok && alt_reg != 2'h0)
				begin
					cnt_next = mps_reg;
					if (!f_ov && mk_reg == 3'h0 && !compress_en)
						st_next = UVS_IDLE;
					st_next = UVS_SEND;
				end
			end
			UVS_SEND:
			begin
				if (cnt_reg == 11'h000)
				begin
					last_next = 1'b1;
					st_next = UVS_IDLE;
				end
				else if (mk_reg != 3'h0)
				begin
					dat_next = `UVS_EOF_BYTE;
					val_next = 1'b1;
					mk_next = mk_reg - 3'h1;
					cnt_next = cnt_reg - 11'h001;
				end
				else if (f_ov)
				begin
					f_or = 1'b1;
					dat_next = f_out[7:0];
					val_next = 1'b1;
					cnt_next = cnt_reg - 11'h001;
					if (f_out[8])
						mk_next = `UVS_EOF_LEN;
				end
				else
				begin
					// short or empty packet when buffer runs dry
					last_next = 1'b1;
					st_next = UVS_IDLE;
				end
			end
			default: st_next = UVS_IDLE;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			alt_reg <= 2'h0;
			st_reg <= UVS_IDLE;
			cnt_reg <= 11'h000;
			mps_reg <= 11'h000;
			ffrun_reg <= 2'h0;
			mk_reg <= 3'h0;
			bw_reg <= 1'b1;
			dat_reg <= 8'h00;
			val_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			alt_reg <= alt_next;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			mps_reg <= mps_next;
			ffrun_reg <= ffrun_next;
			mk_reg <= mk_next;
			bw_reg <= bw_next;
			dat_reg <= dat_next;
			val_reg <= val_next;
			last_reg <= last_next;
		end
	end
	always_comb
	begin
		lnk.rx_data = dat_reg;
		lnk.rx_valid = val_reg;
		lnk.rx_last = last_reg;
		lnk.mps = mps_reg;
		desc_ep_addr = `UVS_EP_ADDR;
		desc_ep_attr = `UVS_EP_ATTR;
		desc_interval = `UVS_EP_INTERVAL;
		desc_mps = mps_reg;
	end
endmodule // uvs_dev

// ==== uvs_host.sv ====
// host end: picks settings, polls once per 1 ms, collects image frames
// assumes the camera end answers each token with one packet
`timescale 1ns/1ps
module uvs_host
	import uvs_pkg::*;
#(
	parameter int FRAME_CYC = `UVS_FRAME_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// user side
	input wire logic start,
	input wire logic [1:0] bus_max_alt,
	output logic [7:0] img_data,
	output logic img_valid,
	output logic img_end,
	// link to camera
	uvs_link_if.host lnk
);
	initial
	begin
		if (FRAME_CYC < 2)
			$error("uvs_host frame count too small");
	end
	logic [31:0] tm_reg, tm_next;
	uvs_alt_t alt_reg, alt_next;
	logic stb_reg, stb_next, tok_reg, tok_next, run_reg, run_next;
	logic [2:0] ff_reg, ff_next;
	logic [7:0] d_reg, d_next;
	logic v_reg, v_next, e_reg, e_next;
	always_comb
	begin
		alt_next = alt_reg;
		stb_next = 1'b0;
		run_next = run_reg;
		// ask once for bus_max_alt, setting 1 when it is 0
		if (start && !run_reg)
		begin
			alt_next = (bus_max_alt == 2'h0) ? 2'h1 : bus_max_alt;
			stb_next = 1'b1;
			run_next = 1'b1;
		end
		tm_next = (tm_reg == FRAME_CYC - 1) ? 32'h0 : tm_reg + 32'h1;
		tok_next = run_reg && tm_reg == 32'h0;
		d_next = lnk.rx_data;
		v_next = lnk.rx_valid && lnk.rx_data != `UVS_EOF_BYTE;
		ff_next = ff_reg;
		e_next = 1'b0;
		if (lnk.rx_valid)
		begin
			ff_next = (lnk.rx_data == `UVS_EOF_BYTE) ? ff_reg + 3'h1 : 3'h0;
			if (ff_reg == 3'h3 && lnk.rx_data == `UVS_EOF_BYTE)
			begin
				e_next = 1'b1;
				ff_next = 3'h0;
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tm_reg <= 32'h0;
			alt_reg <= 2'h0;
			stb_reg <= 1'b1;
			tok_reg <= 1'b0;
			run_reg <= 1'b0;
			ff_reg <= 3'h0;
			d_reg <= 8'h00;
			v_reg <= 1'b0;
			e_reg <= 1'b0;
		end
		else
		begin
			tm_reg <= tm_next;
			alt_reg <= alt_next;
			stb_reg <= stb_next;
			tok_reg <= tok_next;
			run_reg <= run_next;
			ff_reg <= ff_next;
			d_reg <= d_next;
			v_reg <= v_next;
			e_reg <= e_next;
		end
	end
	always_comb
	begin
		lnk.alt_set = alt_reg;
		lnk.alt_set_stb = stb_reg;
		lnk.in_token = tok_reg;
		lnk.ep_addr = `UVS_EP_ADDR;
		img_data = d_reg;
		img_valid = v_reg;
		img_end = e_reg;
	end
endmodule // uvs_host

// ==== uvs_link_assertions.sv ====
// checks on the link between the camera end and the host end
// assumes plain interface signals and one shared clock
`timescale 1ns/1ps
module uvs_link_assertions #(
	parameter int FRAME_CYC = 50
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	input wire logic [1:0] alt_set,
	input wire logic alt_set_stb,
	input wire logic in_token,
	input wire logic [7:0] ep_addr,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic [10:0] mps
);
	logic [10:0] cnt_reg, cnt_next;
	logic [31:0] gap_reg, gap_next;
	logic open_reg, open_next, seen_reg, seen_next;
	always_comb
	begin
		cnt_next = rx_last ? 11'h000 : cnt_reg + {10'h000, rx_valid};
		gap_next = in_token ? 32'h0 : gap_reg + 32'h1;
		open_next = (in_token & (mps != 11'h000)) | (open_reg & ~rx_last);
		seen_next = seen_reg | in_token;
	end
	always_ff @(posedge clk)
	begin
		cnt_reg <= sys_rst ? 11'h000 : cnt_next;
		gap_reg <= sys_rst ? 32'h0 : gap_next;
		open_reg <= sys_rst ? 1'b0 : open_next;
		seen_reg <= sys_rst ? 1'b0 : seen_next;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ep_addr;
		in_token |-> ep_addr == 8'h81;
	endproperty
	a_ep_addr: assert property (p_ep_addr)
		else $error("token to wrong endpoint");
	property p_alt0_size;
		alt_set_stb && alt_set == 2'h0 |-> ##[1:3] mps == 11'h000;
	endproperty
	a_alt0_size: assert property (p_alt0_size)
		else $error("setting 0 reserves bytes");
	property p_alt_size;
		alt_set_stb && alt_set != 2'h0 |-> ##[1:3] mps != 11'h000;
	endproperty
	a_alt_size: assert property (p_alt_size)
		else $error("nonzero setting without size");
	property p_answer;
		in_token && mps != 11'h000 |-> ##[2:3] (rx_valid || rx_last);
	endproperty
	a_answer: assert property (p_answer)
		else $error("token not answered");
	property p_cap;
		rx_valid |-> cnt_reg < mps;
	endproperty
	a_cap: assert property (p_cap)
		else $error("packet longer than size");
	property p_last_pulse;
		rx_last |=> !rx_last;
	endproperty
	a_last_pulse: assert property (p_last_pulse)
		else $error("packet end held");
	property p_gap;
		in_token && seen_reg |-> gap_reg == FRAME_CYC - 1;
	endproperty
	a_gap: assert property (p_gap)
		else $error("token spacing wrong");
	property p_open;
		rx_valid || rx_last |-> open_reg;
	endproperty
	a_open: assert property (p_open)
		else $error("data without token");
	property p_load_alt;
		$fell(sys_rst) |-> ##[0:2] (alt_set_stb && alt_set == 2'h0);
	endproperty
	a_load_alt: assert property (p_load_alt)
		else $error("setting 0 not chosen at start");
endmodule // uvs_link_assertions

// ==== usb_iso_video_stream_bench.sv ====
// testbench joining the camera end and host end through the link
// assumes a short frame count so the run stays brief
`timescale 1ns/1ps
module usb_iso_video_stream_bench;
	import uvs_pkg::*;
	localparam int FC = 50;
	logic clk = 1'b0, sys_rst = 1'b1, bw_hi = 1'b1, start = 1'b0;
	logic vid_valid = 1'b0, vid_eof = 1'b0, compress_en = 1'b1;
	logic [7:0] vid_data = 8'h00;
	logic [1:0] bus_max_alt = 2'h1;
	logic vid_ready, img_valid, img_end;
	logic [7:0] img_data, d_addr, d_attr, d_int;
	logic [10:0] d_mps;
	int errors = 0, n_compared = 0, n_empty = 0, n_end = 0;
	logic [7:0] rxq[$];
	logic [7:0] imgq[$];
	uvs_link_if lnk ();
	uvs_dev #(.DEPTH(16)) uvs_dev_i (.clk(clk), .sys_rst(sys_rst),
		.bw_hi(bw_hi), .vid_data(vid_data), .vid_valid(vid_valid),
		.vid_eof(vid_eof), .compress_en(compress_en),
		.vid_ready(vid_ready), .lnk(lnk), .desc_ep_addr(d_addr),
		.desc_ep_attr(d_attr), .desc_interval(d_int), .desc_mps(d_mps));
	uvs_host #(.FRAME_CYC(FC)) uvs_host_i (.clk(clk), .sys_rst(sys_rst),
		.start(start), .bus_max_alt(bus_max_alt), .img_data(img_data),
		.img_valid(img_valid), .img_end(img_end), .lnk(lnk));
	uvs_link_assertions #(.FRAME_CYC(FC)) uvs_link_assertions_i (
		.clk(clk), .sys_rst(sys_rst), .alt_set(lnk.alt_set),
		.alt_set_stb(lnk.alt_set_stb), .in_token(lnk.in_token),
		.ep_addr(lnk.ep_addr), .rx_data(lnk.rx_data),
		.rx_valid(lnk.rx_valid), .rx_last(lnk.rx_last), .mps(lnk.mps));
	always #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		if (lnk.rx_valid === 1'b1)
			rxq.push_back(lnk.rx_data);
		if (lnk.rx_last === 1'b1 && lnk.rx_valid !== 1'b1)
			n_empty++;
		if (img_end === 1'b1)
			n_end++;
		if (img_valid === 1'b1)
			imgq.push_back(img_data);
	end
	task automatic chk(input logic c, input string m);
		n_compared++;
		if (c !== 1'b1)
		begin
			errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic do_reset();
		@(negedge clk) sys_rst = 1'b1;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		rxq.delete();
		imgq.delete();
	endtask
	// the camera end takes the new setting two edges after start;
	// video offered earlier would still be swallowed by setting 0
	task automatic go();
		@(negedge clk) start = 1'b1;
		@(negedge clk) start = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_idle();
		do_reset();
		chk(d_addr === 8'h81 && d_attr === 8'h01, "descriptor");
		chk(d_int === 8'h01 && lnk.mps === 11'h000, "idle size");
		vid_valid = 1'b1;
		repeat (3 * FC) @(negedge clk);
		chk(vid_ready === 1'b1 && rxq.size() == 0, "idle sent");
		vid_valid = 1'b0;
	endtask
	task automatic t_table();
		logic [10:0] e [2][4] = '{'{11'h000, 11'h140, 11'h268, 11'h380},
			'{11'h000, 11'h1C0, 11'h2C0, 11'h3C0}};
		for (int b = 0; b < 2; b++)
			for (int a = 1; a < 4; a++)
			begin
				bw_hi = b[0];
				bus_max_alt = a[1:0];
				do_reset();
				go();
				repeat (FC + 4) @(negedge clk);
				chk(lnk.mps === e[b][a] && d_mps === e[b][a], "size");
			end
	endtask
	task automatic t_stream();
		logic [7:0] expq[$];
		logic [7:0] d;
		int run = 0;
		logic full = 1'b0;
		bus_max_alt = 2'h1;
		do_reset();
		n_end = 0;
		n_empty = 0;
		go();
		for (int i = 0; i < 24; i++)
		begin
			d = (i >= 5 && i < 9) ? 8'hFF : 8'(i);
			run = (d == 8'hFF) ? run + 1 : 0;
			if (run < 4)
				expq.push_back(d);
			else
				run = 3;
			vid_data = d;
			vid_valid = 1'b1;
			vid_eof = (i == 23);
			while (vid_ready !== 1'b1)
			begin
				full = 1'b1;
				@(negedge clk);
			end
			@(negedge clk);
		end
		vid_valid = 1'b0;
		vid_eof = 1'b0;
		repeat (4) expq.push_back(8'hFF);
		repeat (3 * FC) @(negedge clk);
		chk(full, "buffer never refused");
		chk(rxq == expq, "stream data");
		chk(n_end == 1, "image end count");
		chk(n_empty > 0, "no empty packet");
		chk(imgq.size() > 0 && imgq[0] === 8'h00, "image bytes");
	endtask
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		t_idle();
		t_table();
		t_stream();
		stop_test();
	end
	initial
	begin
		#200000;
		errors++;
		stop_test();
	end
endmodule // usb_iso_video_stream_bench
